// ### hsrc_consts.vh
// Constants for the host strap and reset configuration block
`ifndef HSRC_CONSTS_VH
`define HSRC_CONSTS_VH
`define HSRC_CLK_HZ        20000000
`define HSRC_POR_LOW_US    100
`define HSRC_RUN_LOW_US    10
`define HSRC_POR_LOW_CYC   ((`HSRC_POR_LOW_US * `HSRC_CLK_HZ + 999999) / 1000000)
`define HSRC_RUN_LOW_CYC   ((`HSRC_RUN_LOW_US * `HSRC_CLK_HZ + 999999) / 1000000)
`define HSRC_A_STRAP       12'h000
`define HSRC_A_HOSTCFG     12'h004
`define HSRC_A_EVTCTRL     12'h008
`define HSRC_A_IRQ         12'h00C
`define HSRC_A_HOST2       12'h010
`define HSRC_A_STATUS      12'h014
`define HSRC_STRAP_DEF     8'h13
`define HSRC_EVTCTRL_RST   20'h00002
`define HSRC_M_SER1        4'h0
`define HSRC_M_SER2        4'h1
`define HSRC_M_SER4        4'h2
`define HSRC_M_RGMII       4'h3
`define HSRC_M_RMII        4'h4
`define HSRC_M_FX100       4'h5
`define HSRC_M_SG1000      4'h6
`define HSRC_M_SG100       4'h7
`define HSRC_M_KX1000      4'h8
`define HSRC_F_FUNC_TSN    2'h0
`define HSRC_F_FUNC_LEG    2'h1
`define HSRC_F_FUNC_PTP    2'h2
`define HSRC_F_FUNC_CAP    2'h3
`define HSRC_PORT_MAX      3'h5
`endif

// ### hsrc_strap_cap.v
// Reset release synchroniser and one-shot strap capture
`timescale 1ns/1ps
module hsrc_strap_cap #(
  parameter [7:0] DEFAULT = 8'h13
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire [7:0] strap_in,
  output reg  [7:0] strap_q,
  output reg        captured,
  output wire       released
);
  reg sync1;
  reg sync2;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1 <= 1'b0;
      sync2 <= 1'b0;
    end else begin
      sync1 <= 1'b1;  // [RQ20]
      sync2 <= sync1;
    end
  end

  assign released = sync2;

  // Latch once, then hold until the next reset
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_q  <= DEFAULT;  // [RQ5] [RQ6]
      captured <= 1'b0;
    end else if (sync2 && !captured) begin
      strap_q  <= strap_in;  // [RQ1] [RQ20]
      captured <= 1'b1;
    end
  end
endmodule

// ### hsrc_pin_mux.v
// Function mux and output driver for one event pin
`timescale 1ns/1ps
`include "hsrc_consts.vh"
module hsrc_pin_mux #(
  parameter PTP_OK = 0,
  parameter IRQ_OK = 0
) (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       running,
  input  wire [1:0] func,
  input  wire       gpio_mode,
  input  wire       gpio_out,
  input  wire       gpio_oe,
  input  wire       tsn_in,
  input  wire       legacy_in,
  input  wire       ptp_in,
  input  wire       irq_ok,
  input  wire       irq_in,
  output reg        pin_out,
  output reg        pin_oe
);
  reg next_out;
  reg next_oe;

  always @* begin
    next_out = 1'b0;
    next_oe  = 1'b0;
    if (!running) begin
      next_oe = 1'b0;  // [RQ15]
    end else if (gpio_mode) begin
      next_out = gpio_out;  // [RQ11]
      next_oe  = gpio_oe;
    end else begin
      case (func)
        `HSRC_F_FUNC_TSN: begin
          next_out = tsn_in;  // [RQ12]
          next_oe  = 1'b1;
        end
        `HSRC_F_FUNC_LEG: begin
          next_out = legacy_in;  // [RQ12]
          next_oe  = 1'b1;
        end
        `HSRC_F_FUNC_PTP: begin
          if (PTP_OK != 0) begin
            next_out = ptp_in;  // [RQ12]
            next_oe  = 1'b1;
          end else if (IRQ_OK != 0) begin
            next_out = irq_in;  // [RQ10]
            next_oe  = irq_ok;
          end
        end
        default: begin
          next_oe = 1'b0;  // Capture input, pin left undriven
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 1'b0;
      pin_oe  <= 1'b0;  // [RQ15]
    end else begin
      pin_out <= next_out;
      pin_oe  <= next_oe;
    end
  end
endmodule

// ### hsrc_top.v
// Strap capture, host interface decode, event pins and clock output
// Behaviour
// [RQ1] Latch all straps once after reset release
// [RQ2] Host holds straps steady during capture
// [RQ3] Serial IO straps give host port 0-5
// [RQ4] Drive strength strap one selects high drive
// [RQ5] Unstrapped defaults select single serial host
// [RQ6] Defaults: event 0,1 and select high
// [RQ7] RGMII delay added at one point only
// [RQ8] Straps may add both receive and transmit delay
// [RQ9] Second host interface enabled after communication
// [RQ10] Event pin 0 is serial host interrupt
// [RQ11] Engine controls pins, optional GPIO 4-7
// [RQ12] Timer outputs; PTP and capture on 2,3
// [RQ13] Power-on reset low at least 100 us
// [RQ14] Run-time reset low at least 10 us
// [RQ15] All outputs undriven while reset is low
// [RQ16] Host supplies 25 MHz reference
// [RQ17] Drive 25 MHz reference out for PHYs
// [RQ18] Timer straps choose serial lanes or SerDes mode
// [RQ19] RGMII speed and delays, RMII speed and clock
// [RQ20] Sync release, capture on first edge after
// [RQ21] Reserved port falls back to serial host
//
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
`include "hsrc_consts.vh"
module hsrc_top (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  input  wire        serial_io_0,
  input  wire        serial_io_1,
  input  wire        serial_io_2,
  input  wire        serial_sel,
  input  wire [3:0]  event_pin_in,
  output wire [3:0]  event_pin_out,
  output wire [3:0]  event_pin_oe,
  input  wire [3:0]  tsn_timer,
  input  wire [3:0]  legacy_timer,
  input  wire [1:0]  ptp_timer,
  output reg  [1:0]  capture_in,
  input  wire        osc_input,
  output wire        osc_output,
  output wire        osc_output_oe,
  output reg  [3:0]  host_if_mode,
  output reg  [2:0]  host_port,
  output reg         host_port_valid,
  output reg         host_drive_high,
  output reg         rgmii_rx_delay,
  output reg         rgmii_tx_delay,
  output reg         link_gbit,
  output reg         rmii_100m,
  output reg         rmii_ext_clk,
  output reg         cfg_fallback,
  output reg         cfg_ready,
  output reg         host2_enable,
  output reg  [2:0]  host2_port
);
  localparam [2:0] ST_WAIT = 3'b001;
  localparam [2:0] ST_DEC  = 3'b010;
  localparam [2:0] ST_RUN  = 3'b100;

  wire [7:0] strap_q;
  wire       captured;
  wire       released;
  reg  [2:0] state;
  reg  [2:0] next_state;
  reg  [19:0] evt_ctrl;
  reg         irq_req;
  reg         clk_oe;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture
  // Order: sio2 sio1 sio0 select ev3 ev2 ev1 ev0
  hsrc_strap_cap #(
    .DEFAULT (`HSRC_STRAP_DEF)
  ) u_cap (
    .pclk     (pclk),
    .presetn  (presetn),
    .strap_in ({serial_io_2, serial_io_1, serial_io_0, serial_sel, event_pin_in}),  // [RQ2]
    .strap_q  (strap_q),
    .captured (captured),
    .released (released)
  );

  wire [2:0] s_sio = strap_q[7:5];
  wire       s_sel = strap_q[4];
  wire [3:0] s_evt = strap_q[3:0];

  ////////////////////////////////////////////////////////////////////////////
  // Strap decode
  reg [3:0] next_mode;
  reg       next_port_valid;
  reg       next_drive;
  reg       next_rx;
  reg       next_tx;
  reg       next_gbit;
  reg       next_r100;
  reg       next_ext;
  reg       next_fb;
  reg       is_eth;
  reg       serdes;

  always @* begin
    next_mode       = `HSRC_M_SER1;
    next_port_valid = 1'b0;
    next_drive      = 1'b0;
    next_rx         = 1'b0;
    next_tx         = 1'b0;
    next_gbit       = 1'b0;
    next_r100       = 1'b0;
    next_ext        = 1'b0;
    next_fb         = 1'b0;
    is_eth          = 1'b0;
    serdes          = 1'b0;
    if (s_sel) begin
      if (s_evt[1:0] == 2'b11) begin
        case (s_evt[3:2])
          2'b00: begin
            next_mode  = `HSRC_M_SER1;  // [RQ18]
            next_drive = s_sio[2];  // [RQ4]
          end
          2'b10: begin
            next_mode  = `HSRC_M_SER2;  // [RQ18]
            next_drive = s_sio[2];  // [RQ4]
          end
          default: begin
            next_mode  = `HSRC_M_SER4;  // [RQ18]
            next_drive = s_evt[3];  // [RQ4]
          end
        endcase
      end else begin
        is_eth     = 1'b1;
        next_drive = s_sel;  // [RQ4]
      end
    end else begin
      is_eth = 1'b1;
      if (s_evt[1:0] == 2'b11) begin
        serdes = 1'b1;
        case (s_evt[3:2])
          2'b00:   next_mode = `HSRC_M_FX100;  // [RQ18]
          2'b01:   next_mode = `HSRC_M_SG1000;
          2'b10:   next_mode = `HSRC_M_SG100;
          default: next_mode = `HSRC_M_KX1000;
        endcase
      end
    end
    if (is_eth && !serdes) begin
      next_drive = s_sel;  // [RQ4]
      next_gbit  = s_evt[3];  // [RQ19]
      case (s_evt[2:0])
        3'b000: next_mode = `HSRC_M_RGMII;  // [RQ19]
        3'b001: begin
          next_mode = `HSRC_M_RGMII;
          next_rx   = 1'b1;  // [RQ7] [RQ19]
        end
        3'b010: begin
          next_mode = `HSRC_M_RGMII;
          next_tx   = 1'b1;  // [RQ7] [RQ19]
        end
        3'b101: begin
          next_mode = `HSRC_M_RGMII;
          next_rx   = 1'b1;  // [RQ8]
          next_tx   = 1'b1;  // [RQ8]
        end
        3'b100: begin
          next_mode = `HSRC_M_RMII;  // [RQ19]
          next_ext  = s_evt[3];
          next_gbit = 1'b0;
        end
        default: begin
          next_mode = `HSRC_M_RMII;  // [RQ19]
          next_r100 = 1'b1;
          next_ext  = s_evt[3];
          next_gbit = 1'b0;
        end
      endcase
    end
    if (is_eth) begin
      next_port_valid = 1'b1;  // [RQ3]
      if (s_sio > `HSRC_PORT_MAX) begin
        next_port_valid = 1'b0;  // [RQ21]
      end else if (serdes && (s_sio == 3'h0 || s_sio == `HSRC_PORT_MAX)) begin
        next_port_valid = 1'b0;  // [RQ3]
      end
      if (!next_port_valid) begin
        next_mode  = `HSRC_M_SER1;  // [RQ21]
        next_fb    = 1'b1;
        next_rx    = 1'b0;
        next_tx    = 1'b0;
        next_gbit  = 1'b0;
        next_r100  = 1'b0;
        next_ext   = 1'b0;
        next_drive = 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer: wait for capture, load decode once, run
  always @* begin
    next_state = state;
    case (state)
      ST_WAIT: if (captured) next_state = ST_DEC;
      ST_DEC:  next_state = ST_RUN;
      ST_RUN:  next_state = ST_RUN;
      default: next_state = ST_WAIT;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= ST_WAIT;
      host_if_mode    <= `HSRC_M_SER1;
      host_port       <= 3'h0;
      host_port_valid <= 1'b0;
      host_drive_high <= 1'b0;
      rgmii_rx_delay  <= 1'b0;
      rgmii_tx_delay  <= 1'b0;
      link_gbit       <= 1'b0;
      rmii_100m       <= 1'b0;
      rmii_ext_clk    <= 1'b0;
      cfg_fallback    <= 1'b0;
      cfg_ready       <= 1'b0;
      clk_oe          <= 1'b0;  // [RQ15]
    end else begin
      state  <= next_state;
      clk_oe <= released;  // [RQ17]
      if (state == ST_DEC) begin
        host_if_mode    <= next_mode;  // [RQ18]
        host_port       <= s_sio;  // [RQ3]
        host_port_valid <= next_port_valid;
        host_drive_high <= next_drive;  // [RQ4]
        rgmii_rx_delay  <= next_rx;  // [RQ8]
        rgmii_tx_delay  <= next_tx;  // [RQ8]
        link_gbit       <= next_gbit;
        rmii_100m       <= next_r100;
        rmii_ext_clk    <= next_ext;
        cfg_fallback    <= next_fb;  // [RQ21]
        cfg_ready       <= 1'b1;
      end
    end
  end

  // Reference clock passes straight through, undriven in reset
  assign osc_output    = osc_input & clk_oe;  // [RQ17]
  assign osc_output_oe = clk_oe;  // [RQ15]

  ////////////////////////////////////////////////////////////////////////////
  // Event pins
  wire running = (state == ST_RUN);
  wire ser_host = (host_if_mode == `HSRC_M_SER1) || (host_if_mode == `HSRC_M_SER2) ||
                  (host_if_mode == `HSRC_M_SER4);
  wire [3:0] ptp_map = {ptp_timer, 2'b00};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_pin
      hsrc_pin_mux #(
        .PTP_OK (gi >= 2),
        .IRQ_OK (gi == 0)
      ) u_pin (
        .pclk      (pclk),
        .presetn   (presetn),
        .running   (running),
        .func      (evt_ctrl[2*gi+1:2*gi]),  // [RQ11]
        .gpio_mode (evt_ctrl[8+gi]),  // [RQ11]
        .gpio_out  (evt_ctrl[12+gi]),
        .gpio_oe   (evt_ctrl[16+gi]),
        .tsn_in    (tsn_timer[gi]),
        .legacy_in (legacy_timer[gi]),
        .ptp_in    (ptp_map[gi]),
        .irq_ok    (ser_host),  // [RQ10]
        .irq_in    (irq_req),
        .pin_out   (event_pin_out[gi]),
        .pin_oe    (event_pin_oe[gi])
      );
    end
  endgenerate

  // Capture inputs exist only on pins 2 and 3
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      capture_in <= 2'b00;
    end else begin
      capture_in[0] <= running && !evt_ctrl[10] &&
                       (evt_ctrl[5:4] == `HSRC_F_FUNC_CAP) && event_pin_in[2];  // [RQ12]
      capture_in[1] <= running && !evt_ctrl[11] &&
                       (evt_ctrl[7:6] == `HSRC_F_FUNC_CAP) && event_pin_in[3];  // [RQ12]
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // APB slave, zero wait states
  wire wr_en = psel && penable && pwrite;
  wire rd_setup = psel && !penable;
  reg  mapped;
  reg  [31:0] rd_mux;

  always @* begin
    mapped = 1'b1;
    rd_mux = 32'h00000000;
    if (paddr == `HSRC_A_STRAP) begin
      rd_mux[7:0] = strap_q;
    end else if (paddr == `HSRC_A_HOSTCFG) begin
      rd_mux[15:0] = {cfg_ready, cfg_fallback, rmii_ext_clk, rmii_100m, link_gbit,
                      rgmii_tx_delay, rgmii_rx_delay, host_drive_high, host_port_valid,
                      host_port, host_if_mode};
    end else if (paddr == `HSRC_A_EVTCTRL) begin
      rd_mux[19:0] = evt_ctrl;
    end else if (paddr == `HSRC_A_IRQ) begin
      rd_mux[0] = irq_req;
    end else if (paddr == `HSRC_A_HOST2) begin
      rd_mux[3:0] = {host2_port, host2_enable};
    end else if (paddr == `HSRC_A_STATUS) begin
      rd_mux[6:0] = {captured, capture_in, event_pin_in};
    end else begin
      mapped = 1'b0;
    end
  end

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata       <= 32'h00000000;
      evt_ctrl     <= `HSRC_EVTCTRL_RST;  // [RQ10]
      irq_req      <= 1'b0;
      host2_enable <= 1'b0;
      host2_port   <= 3'h0;
    end else begin
      if (rd_setup && !pwrite) begin
        prdata <= rd_mux;
      end
      if (wr_en && paddr == `HSRC_A_EVTCTRL) begin
        evt_ctrl <= pwdata[19:0];  // [RQ11]
      end
      if (wr_en && paddr == `HSRC_A_IRQ) begin
        irq_req <= pwdata[0];  // [RQ10]
      end
      // Second interface only once the strapped one is up
      if (wr_en && paddr == `HSRC_A_HOST2 && cfg_ready) begin
        host2_enable <= pwdata[0];  // [RQ9]
        host2_port   <= pwdata[3:1];
      end
    end
  end
endmodule

// ### hsrc_checker.sv
// Assertion checker for the host strap and reset block
`timescale 1ns/1ps
module hsrc_checker (
  input wire       pclk,
  input wire       presetn,
  input wire       osc_input,
  input wire       osc_output,
  input wire       osc_output_oe,
  input wire [3:0] event_pin_oe,
  input wire [3:0] host_if_mode,
  input wire [2:0] host_port,
  input wire       host_port_valid,
  input wire       host_drive_high,
  input wire       link_gbit,
  input wire       rgmii_rx_delay,
  input wire       rgmii_tx_delay,
  input wire       cfg_fallback,
  input wire       cfg_ready
);
  wire [13:0] cfg_all = {host_if_mode, host_port, host_port_valid, host_drive_high, link_gbit,
                         rgmii_rx_delay, rgmii_tx_delay, cfg_fallback, cfg_ready};
  default clocking dc @(posedge pclk); endclocking
  default disable iff (!presetn);
  chk_reset_hiz: assert property (disable iff (1'h0)
    !presetn |-> event_pin_oe == 4'h0 && !osc_output_oe) else $error("pin driven in reset");
  chk_ready_delay: assert property ($rose(presetn) |-> !cfg_ready ##[1:5] cfg_ready)
    else $error("config not ready in time");
  chk_ready_hold: assert property (cfg_ready |=> cfg_ready)
    else $error("config ready dropped");
  chk_cfg_frozen: assert property (cfg_ready |=> $stable(cfg_all))
    else $error("captured config changed");
  chk_port_range: assert property (host_port_valid |-> host_port <= 3'h5)
    else $error("reserved host port marked valid");
  chk_serial_noport: assert property (cfg_ready && host_if_mode <= 4'h2
    |-> !host_port_valid) else $error("serial host with ethernet port");
  chk_fallback_mode: assert property (cfg_fallback |->
    host_if_mode == 4'h0 && !host_port_valid && !host_drive_high) else $error("bad fallback");
  chk_rmii_slow: assert property (host_if_mode == 4'h4 |-> !link_gbit)
    else $error("rmii at gigabit");
  chk_osc_out: assert property (cfg_ready |-> osc_output_oe && osc_output == osc_input)
    else $error("reference clock not passed out");
  cover property (cfg_fallback);
  cover property (host_if_mode == 4'h3 && rgmii_rx_delay && rgmii_tx_delay);
  cover property (host_if_mode == 4'h2 && host_drive_high);
endmodule

bind hsrc_top hsrc_checker u_chk (.*);

// ### hsrc_host_model.sv
// Host board model: reset pin, strap levels, event pin wires, reference clock
`timescale 1ns/1ps
module hsrc_host_model (
  input  wire       pclk,
  input  wire [3:0] event_pin_out,
  input  wire [3:0] event_pin_oe,
  output reg        presetn,
  output reg  [7:0] strap,
  output wire [3:0] event_pin_in,
  output reg        osc_input
);
  // Device drive wins where enabled, else the board level
  assign event_pin_in = (event_pin_oe & event_pin_out) | (~event_pin_oe & strap[3:0]);
  initial begin
    presetn = 1'h0;
    strap = 8'h13;
    osc_input = 1'h0;
  end
  always #20 osc_input = ~osc_input;
  // Straps set while reset is low, held until the caller moves them
  task apply(input [7:0] s, input integer low);
    begin
      presetn <= 1'h0;
      strap <= s;
      repeat (low) @(posedge pclk);
      presetn <= 1'h1;
    end
  endtask
endmodule

// ### hsrc_top_tb.sv
// Self-checking bench for the host strap and reset block
`timescale 1ns/1ps
`include "hsrc_consts.vh"
module hsrc_top_tb;
  localparam [151:0] TBL = 152'hE507D08F6B47235E26BC841D6259201F179B1B;
  reg         pclk, psel, penable, pwrite, er;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd, em, r;
  reg  [3:0]  tsn_timer, legacy_timer;
  reg  [1:0]  ptp_timer;
  reg  [7:0]  s;
  wire [31:0] prdata;
  wire [7:0]  strap;
  wire [3:0]  event_pin_in, event_pin_out, event_pin_oe, host_if_mode;
  wire [2:0]  host_port, host2_port;
  wire [1:0]  capture_in;
  wire        pready, pslverr, presetn, osc_input, osc_output, osc_output_oe;
  wire        host_port_valid, host_drive_high, rgmii_rx_delay, rgmii_tx_delay, link_gbit;
  wire        rmii_100m, rmii_ext_clk, cfg_fallback, cfg_ready, host2_enable;
  wire        serial_io_2 = strap[7];
  wire        serial_io_1 = strap[6];
  wire        serial_io_0 = strap[5];
  wire        serial_sel = strap[4];
  wire [15:0] cfg_seen = {cfg_ready, cfg_fallback, rmii_ext_clk, rmii_100m, link_gbit,
                          rgmii_tx_delay, rgmii_rx_delay, host_drive_high, host_port_valid,
                          host_port, host_if_mode};
  integer     failures, compares, seed, i, n;

  hsrc_top DUT (.*);
  hsrc_host_model host (.pclk(pclk), .event_pin_out(event_pin_out), .event_pin_oe(event_pin_oe),
    .presetn(presetn), .strap(strap), .event_pin_in(event_pin_in), .osc_input(osc_input));

  initial pclk = 1'h0;
  always #25 pclk = ~pclk;

  ////////////////////////////////////////////////////////////////////////////////////////////
  // Expected decode: upper half is the compare mask, lower half the value
  function [31:0] model(input [7:0] v);
    reg [2:0] l;
    reg       fb;
    begin
      model = 32'hFFFF8000;
      l = v[2:0];
      fb = v[7:6] == 2'h3;
      if (v[4] && v[1:0] == 2'h3) begin
        model[3:0] = v[2] ? 4'h2 : {3'h0, v[3]};
        model[8] = v[2] ? v[3] : v[7];
        model[22:20] = 3'h0;
        fb = 1'h0;
      end else begin
        model[8:4] = {v[4], 1'h1, v[7:5]};
        if (v[1:0] == 2'h3) begin
          model[3:0] = 4'h5 + {2'h0, v[3:2]};
          model[27] = 1'h0;
          fb = fb | v[7:5] == 3'h0 | v[7:5] == 3'h5;
        end else if (l == 3'h4 || l == 3'h6) begin
          model[3:0] = 4'h4;
          model[13:12] = {v[3], v[1]};
        end else begin
          model[3:0] = 4'h3;
          model[11:9] = {v[3], l == 3'h2 || l == 3'h5, l == 3'h1 || l == 3'h5};
        end
      end
      if (fb)
        model = 32'hC18FC000;
    end
  endfunction

  task chk(input [79:0] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e) begin
        failures = failures + 1;
        $display("[ERR] %0s expected %h seen %h", nm, e, g);
      end
    end
  endtask

  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1)
        @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge pclk);
    end
  endtask

  task pins(input [19:0] ctl, input [3:0] eo, input [3:0] eoe);
    begin
      apb(1'h1, `HSRC_A_EVTCTRL, {12'h0, ctl});
      repeat (3) @(posedge pclk);
      chk("pin_oe", {28'h0, eoe}, {28'h0, event_pin_oe});
      chk("pin_out", {28'h0, eo & eoe}, {28'h0, event_pin_out & eoe});
    end
  endtask

  task test_done;
    begin
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////////////////
  initial begin
    failures = 0;
    compares = 0;
    seed = 2755;
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    {tsn_timer, legacy_timer, ptp_timer} = 10'h0;
    @(posedge pclk);
    for (i = 0; i < 25; i = i + 1) begin
      if (i < 19)
        s = TBL[i*8 +: 8];
      else if (i < 24)
        s = $random(seed);
      else
        s = 8'h13;
      fork
        host.apply(s, i == 0 ? `HSRC_POR_LOW_CYC : `HSRC_RUN_LOW_CYC);
        begin
          repeat (3) @(posedge pclk);
          chk("hiz_oe", 32'h0, {27'h0, event_pin_oe, osc_output_oe});
        end
      join
      if (i == 1)
        apb(1'h1, `HSRC_A_HOST2, 32'h7);
      n = 0;
      while (cfg_ready !== 1'h1 && n < 20) begin
        @(posedge pclk);
        n = n + 1;
      end
      chk("ready", 32'h1, {31'h0, n < 20});
      if (i == 1)
        chk("host2_pre", 32'h0, {28'h0, host2_port, host2_enable});
      em = model(s);
      chk("cfg_pins", em[15:0] & em[31:16], cfg_seen & em[31:16]);
      apb(1'h0, `HSRC_A_HOSTCFG, 32'h0);
      chk("hostcfg", {16'h0, em[15:0] & em[31:16]}, rd & {16'hFFFF, em[31:16]});
      apb(1'h0, `HSRC_A_STRAP, 32'h0);
      chk("strap", {24'h0, s}, rd);
      host.strap <= ~s;
      repeat (4) @(posedge pclk);
      chk("cfg_held", em[15:0] & em[31:16], cfg_seen & em[31:16]);
    end
    chk("osc_oe", 32'h1, {31'h0, osc_output_oe});
    apb(1'h0, `HSRC_A_EVTCTRL, 32'h0);
    chk("evt_reset", 32'h2, rd);
    apb(1'h1, `HSRC_A_IRQ, 32'h1);
    repeat (3) @(posedge pclk);
    chk("irq_pin", 32'h3, {30'h0, event_pin_oe[0], event_pin_out[0]});
    r = $random(seed);
    tsn_timer <= r[3:0];
    legacy_timer <= r[7:4];
    ptp_timer <= r[9:8];
    pins(20'h00000, r[3:0], 4'hF);
    pins(20'h00055, r[7:4], 4'hF);
    pins(20'h000A0, {r[9:8], r[1:0]}, 4'hF);
    pins(20'h000F0, r[3:0], 4'h3);
    chk("capture", {30'h0, ~s[3:2]}, {30'h0, capture_in});
    pins(20'hF5F00, 4'h5, 4'hF);
    pins(20'h3AF00, 4'hA, 4'h3);
    apb(1'h0, 12'h020, 32'h0);
    chk("unmapped", 32'h1, {31'h0, er});
    chk("unmap_rd", 32'h0, rd);
    apb(1'h1, `HSRC_A_HOST2, 32'h7);
    repeat (2) @(posedge pclk);
    chk("host2", 32'h7, {28'h0, host2_port, host2_enable});
    test_done;
  end

  initial begin
    #2000000;
    failures = failures + 1;
    test_done;
  end
endmodule
